// ### shared/scale_io_consts.svh
// bit positions and codes of the quarter rack words
`ifndef SCALE_IO_CONSTS_SVH
`define SCALE_IO_CONSTS_SVH
`define WORD_W 16
`define ST_SP1 0
`define ST_SP2 1
`define ST_ZTOL 2
`define ST_DIN 9
`define ST_MOTION 12
`define ST_NET 13
`define ST_UPDATING 14
`define ST_DATA_OK 15
`define CMD_SEL_LO 0
`define CMD_SEL_HI 2
`define CMD_LOAD_TARE 3
`define CMD_CLR_TARE 4
`define CMD_PB_TARE 5
`define CMD_PRINT 6
`define CMD_ZERO 7
`define CMD_SP_ENABLE 8
`define CMD_POUT_ONE 12
`define CMD_POUT_TWO 13
`define CMD_POUT_THREE 14
`define CMD_LOAD_SP1 15
`define CMD_USED_MASK 16'hf1ff
`define SEL_GROSS 3'h0
`define SEL_NET 3'h1
`define SEL_DISPLAYED 3'h2
`define SEL_TARE 3'h3
`define SEL_SP1 3'h4
`define RACK_MAX 7'h40
`define QUARTER_MIN 3'h1
`define QUARTER_MAX 3'h4
`define ZERO_WORD 16'h0000
`endif

// ### shared/scale_io_pkg.sv
// types of the quarter rack exchange block
`default_nettype none
package scale_io_pkg;
   typedef struct packed {
      logic [15:0] weight_value_in;
      logic [15:0] scale_status_in;
      logic [15:0] tare_setpoint_value_out;
      logic [15:0] command_control_out;
      logic [15:0] cmd_seen;
      logic [15:0] preset_tare;
      logic [15:0] setpoint1_value;
      logic [15:0] nv_setpoint1;
      logic sp1_pending;
      logic preset_tare_load;
      logic clear_tare_cmd;
      logic pb_tare_cmd;
      logic print_cmd;
      logic zero_cmd;
      logic setpoint1_load;
      logic nv_store;
      logic high_level_enable;
      logic [2:0] parallel_out;
      logic [15:0] rd_word0;
      logic [15:0] rd_word1;
      logic rd_valid;
   } io_state_t;
endpackage
`default_nettype wire

// ### rtl/scale_plc_quarter_rack_io.sv
// quarter rack discrete exchange between weighing terminal and controller
//
// Function
// (R1) two 16-bit read words and two 16-bit write words, 32 bits each way
// (R2) data refreshed only on the A/D conversion pulse, not the controller scan
// (R3) read word 0 weight chosen by command bits 0-2; codes 5-7 give gross
// (R4) status bit 15 high only when scale healthy; otherwise weight reads zero
// (R5) status bit 14 set when read collides with an update; controller rereads
// (R6) status bit 12 shows motion, bit 13 net mode, both active high
// (R7) status bit 9 mirrors the discrete input level
// (R8) status bits 0-2 show setpoint or over/under outputs depending on mode
// (R9) controller writes word 0 as a signed 16-bit binary value
// (R10) rising command bit 3 copies word 0 into the preset tare register
// (R11) clear tare, pushbutton tare, print, zero fire only on rising edges
// (R12) command bit 8 enables or disables the high-level outputs
// (R13) raising bit 8 after a setpoint 1 download stores it non-volatile
// (R14) rising bit 15 loads setpoint 1; non-volatile copy only if enabled
// (R15) command bits 12-14 drive parallel outputs, only in indicator mode
// (R16) with interlocks on, a tare onto an existing tare is refused
// (R17) with interlocks on, clear tare is honoured only at gross zero
// (R18) answers at configured rack 0 to 64 and starting quarter 1 to 4
// (R19) unused status bits read zero; unused command bits are ignored
`default_nettype none
`include "scale_io_consts.svh"
module scale_plc_quarter_rack_io #(
   parameter int WIDTH = `WORD_W
) (
   input wire logic clk,
   input wire logic arst_n,
   // node address setup
   input wire logic [6:0] cfg_rack_addr,
   input wire logic [2:0] cfg_start_quarter,
   // controller write of the two output words
   input wire logic plc_wr_valid,
   input wire logic [6:0] plc_wr_rack,
   input wire logic [2:0] plc_wr_quarter,
   input wire logic [WIDTH-1:0] plc_wr_word0,
   input wire logic [WIDTH-1:0] plc_wr_word1,
   // controller read of the two input words
   input wire logic plc_rd_req,
   input wire logic [6:0] plc_rd_rack,
   input wire logic [2:0] plc_rd_quarter,
   output logic plc_rd_valid,
   output logic [WIDTH-1:0] plc_rd_word0,
   output logic [WIDTH-1:0] plc_rd_word1,
   // terminal side
   input wire logic ad_sample,
   input wire logic [WIDTH-1:0] gross_weight,
   input wire logic [WIDTH-1:0] net_weight,
   input wire logic [WIDTH-1:0] displayed_weight,
   input wire logic [WIDTH-1:0] tare_weight,
   input wire logic [WIDTH-1:0] active_target,
   input wire logic over_range,
   input wire logic under_range,
   input wire logic powering_up,
   input wire logic expanded_mode,
   input wire logic setup_mode,
   input wire logic motion,
   input wire logic net_mode,
   input wire logic discrete_input_level,
   input wire logic over_under_mode,
   input wire logic sp1_output,
   input wire logic sp2_output,
   input wire logic zero_tol_output,
   input wire logic under_output,
   input wire logic in_tol_output,
   input wire logic over_output,
   input wire logic indicator_mode,
   input wire logic tare_interlock,
   input wire logic tare_in_use,
   input wire logic gross_at_zero,
   output logic [WIDTH-1:0] preset_tare,
   output logic preset_tare_load,
   output logic clear_tare_cmd,
   output logic pb_tare_cmd,
   output logic print_cmd,
   output logic zero_cmd,
   output logic [WIDTH-1:0] setpoint1_value,
   output logic setpoint1_load,
   output logic [WIDTH-1:0] nv_setpoint1,
   output logic nv_store,
   output logic high_level_enable,
   output logic parallel_output_one,
   output logic parallel_output_two,
   output logic parallel_output_three
);

   scale_io_pkg::io_state_t state;
   scale_io_pkg::io_state_t next_state;

   // node match; out-of-range setup never matches
   function automatic logic addr_hit(input logic [6:0] rack, input logic [2:0] quarter);
      logic ok;
      ok = (cfg_rack_addr <= `RACK_MAX) && (cfg_start_quarter >= `QUARTER_MIN) &&
           (cfg_start_quarter <= `QUARTER_MAX);
      addr_hit = ok && (rack == cfg_rack_addr) && (quarter == cfg_start_quarter);
   endfunction

   logic wr_hit;
   logic rd_hit;
   logic data_ok;
   logic [WIDTH-1:0] sel_weight;
   logic [WIDTH-1:0] status_word;
   logic [WIDTH-1:0] cmd;
   logic [WIDTH-1:0] rise;
   logic tare_allowed;
   logic clear_allowed;

   assign wr_hit = plc_wr_valid && addr_hit(plc_wr_rack, plc_wr_quarter); // (R18)
   assign rd_hit = plc_rd_req && addr_hit(plc_rd_rack, plc_rd_quarter); // (R18)

   assign data_ok = !(over_range || under_range || powering_up || expanded_mode ||
                      setup_mode); // (R4)
   // unused command bits masked so they cannot steer anything
   assign cmd = state.command_control_out & `CMD_USED_MASK; // (R19)
   assign rise = cmd & ~state.cmd_seen; // (R11)

   // interlock refuses only a tare stacked on an existing one or a clear tare away from gross zero
   assign tare_allowed = !(tare_interlock && tare_in_use); // (R16)
   assign clear_allowed = !tare_interlock || gross_at_zero; // (R17)

   always_comb begin
      case (cmd[`CMD_SEL_HI:`CMD_SEL_LO]) // (R3)
         `SEL_NET: sel_weight = net_weight;
         `SEL_DISPLAYED: sel_weight = displayed_weight;
         `SEL_TARE: sel_weight = over_under_mode ? active_target : tare_weight;
         `SEL_SP1: sel_weight = state.setpoint1_value;
         default: sel_weight = gross_weight;
      endcase
   end

   always_comb begin
      status_word = `ZERO_WORD; // (R19)
      status_word[`ST_DATA_OK] = data_ok; // (R4)
      status_word[`ST_MOTION] = motion; // (R6)
      status_word[`ST_NET] = net_mode; // (R6)
      status_word[`ST_DIN] = discrete_input_level; // (R7)
      status_word[`ST_SP1] = over_under_mode ? under_output : sp1_output; // (R8)
      status_word[`ST_SP2] = over_under_mode ? in_tol_output : sp2_output; // (R8)
      status_word[`ST_ZTOL] = over_under_mode ? over_output : zero_tol_output; // (R8)
   end

   always_comb begin
      next_state = state;
      next_state.preset_tare_load = 1'b0;
      next_state.clear_tare_cmd = 1'b0;
      next_state.pb_tare_cmd = 1'b0;
      next_state.print_cmd = 1'b0;
      next_state.zero_cmd = 1'b0;
      next_state.setpoint1_load = 1'b0;
      next_state.nv_store = 1'b0;
      next_state.rd_valid = 1'b0;

      // controller words land at once but act only on the next conversion
      if (wr_hit) begin
         next_state.tare_setpoint_value_out = plc_wr_word0; // (R9)
         next_state.command_control_out = plc_wr_word1; // (R1)
      end

      if (ad_sample) begin // (R2)
         next_state.weight_value_in = data_ok ? sel_weight : `ZERO_WORD; // (R4)
         next_state.scale_status_in = status_word;
         next_state.cmd_seen = cmd;
         next_state.high_level_enable = cmd[`CMD_SP_ENABLE]; // (R12)
         if (indicator_mode) begin
            next_state.parallel_out = {cmd[`CMD_POUT_THREE], cmd[`CMD_POUT_TWO],
                                       cmd[`CMD_POUT_ONE]}; // (R15)
         end
         if (rise[`CMD_LOAD_TARE] && tare_allowed) begin
            next_state.preset_tare = state.tare_setpoint_value_out; // (R10)
            next_state.preset_tare_load = 1'b1; // (R10)
         end
         next_state.clear_tare_cmd = rise[`CMD_CLR_TARE] && clear_allowed; // (R11)
         next_state.pb_tare_cmd = rise[`CMD_PB_TARE] && tare_allowed; // (R11)
         next_state.print_cmd = rise[`CMD_PRINT]; // (R11)
         next_state.zero_cmd = rise[`CMD_ZERO]; // (R11)
         if (rise[`CMD_LOAD_SP1]) begin
            next_state.setpoint1_value = state.tare_setpoint_value_out; // (R14)
            next_state.setpoint1_load = 1'b1;
            if (cmd[`CMD_SP_ENABLE]) begin
               next_state.nv_setpoint1 = state.tare_setpoint_value_out; // (R14)
               next_state.nv_store = 1'b1;
               next_state.sp1_pending = 1'b0;
            end else begin
               next_state.sp1_pending = 1'b1;
            end
         end else if (rise[`CMD_SP_ENABLE] && state.sp1_pending) begin
            // a held-high enable does not re-store; only its rising edge commits
            next_state.nv_setpoint1 = state.setpoint1_value; // (R13)
            next_state.nv_store = 1'b1; // (R13)
            next_state.sp1_pending = 1'b0;
         end
      end

      if (rd_hit) begin
         next_state.rd_valid = 1'b1;
         next_state.rd_word0 = state.weight_value_in;
         next_state.rd_word1 = state.scale_status_in;
         // a read in the refresh cycle returns both words from before this update, flagged
         next_state.rd_word1[`ST_UPDATING] = ad_sample; // (R5)
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign plc_rd_valid = state.rd_valid;
   assign plc_rd_word0 = state.rd_word0;
   assign plc_rd_word1 = state.rd_word1;
   assign preset_tare = state.preset_tare;
   assign preset_tare_load = state.preset_tare_load;
   assign clear_tare_cmd = state.clear_tare_cmd;
   assign pb_tare_cmd = state.pb_tare_cmd;
   assign print_cmd = state.print_cmd;
   assign zero_cmd = state.zero_cmd;
   assign setpoint1_value = state.setpoint1_value;
   assign setpoint1_load = state.setpoint1_load;
   assign nv_setpoint1 = state.nv_setpoint1;
   assign nv_store = state.nv_store;
   assign high_level_enable = state.high_level_enable;
   assign parallel_output_one = state.parallel_out[0];
   assign parallel_output_two = state.parallel_out[1];
   assign parallel_output_three = state.parallel_out[2];

endmodule
`default_nettype wire

// ### tb/scale_io_sva.sv
// port assertions of the quarter rack exchange block
`default_nettype none
module scale_io_sva #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [6:0] cfg_rack_addr,
   input wire logic [2:0] cfg_start_quarter,
   input wire logic plc_rd_req,
   input wire logic [6:0] plc_rd_rack,
   input wire logic [2:0] plc_rd_quarter,
   input wire logic plc_rd_valid,
   input wire logic [WIDTH-1:0] plc_rd_word0,
   input wire logic [WIDTH-1:0] plc_rd_word1,
   input wire logic ad_sample,
   input wire logic tare_interlock,
   input wire logic tare_in_use,
   input wire logic gross_at_zero,
   input wire logic pb_tare_cmd,
   input wire logic clear_tare_cmd,
   input wire logic print_cmd,
   input wire logic parallel_output_one
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   logic hit;
   assign hit = plc_rd_req && {plc_rd_rack, plc_rd_quarter} == {cfg_rack_addr, cfg_start_quarter}
      && cfg_rack_addr <= 7'h40 && cfg_start_quarter inside {[3'h1:3'h4]};
   sequence taken;
      hit;
   endsequence
   sequence answered;
      plc_rd_valid;
   endsequence
   rd_answer_a: assert property (taken |=> answered) else $error("read not answered");
   rd_refuse_a: assert property (!hit |=> !plc_rd_valid) else $error("unasked answer");
   upd_flag_a: assert property (taken ##0 ad_sample |=> plc_rd_word1[14])
      else $error("update flag low");
   upd_clear_a: assert property (hit && !ad_sample |=> !plc_rd_word1[14])
      else $error("update flag high");
   unused_zero_a: assert property (plc_rd_valid |-> (plc_rd_word1 & 16'h0df8) == 16'h0000)
      else $error("unused status bit set");
   zero_weight_a: assert property (plc_rd_valid && !plc_rd_word1[15] |-> plc_rd_word0 == '0)
      else $error("weight not zeroed");
   pulse_once_a: assert property (print_cmd |-> $past(ad_sample) ##1 !print_cmd)
      else $error("print pulse wrong");
   tare_lock_a: assert property (pb_tare_cmd |->
      !($past(tare_interlock) && $past(tare_in_use))) else $error("tare onto tare");
   clr_lock_a: assert property (clear_tare_cmd |->
      !$past(tare_interlock) || $past(gross_at_zero)) else $error("clear off zero");
   out_refresh_a: assert property ($changed(parallel_output_one) |-> $past(ad_sample))
      else $error("output moved between samples");
endmodule
`default_nettype wire

// ### tb/plc_model.sv
// controller side model: writes the command words and asks for reads
`default_nettype none
module plc_model (
   input wire logic clk,
   output logic plc_wr_valid,
   output logic [6:0] plc_wr_rack,
   output logic [2:0] plc_wr_quarter,
   output logic [15:0] plc_wr_word0,
   output logic [15:0] plc_wr_word1,
   output logic plc_rd_req,
   output logic [6:0] plc_rd_rack,
   output logic [2:0] plc_rd_quarter
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {plc_wr_valid, plc_wr_rack, plc_wr_quarter, plc_wr_word0, plc_wr_word1} = '0;
      {plc_rd_req, plc_rd_rack, plc_rd_quarter} = '0;
   end
   // released lines show the inverse so a late sample cannot pass
   task automatic write(input logic [9:0] a, input logic [15:0] w0, input logic [15:0] w1);
      @(posedge clk);
      plc_wr_valid <= 1'h1;
      {plc_wr_rack, plc_wr_quarter} <= a;
      plc_wr_word0 <= w0;
      plc_wr_word1 <= w1;
      @(posedge clk);
      plc_wr_valid <= '0;
      {plc_wr_rack, plc_wr_quarter, plc_wr_word0, plc_wr_word1} <= ~{a, w0, w1};
   endtask
   task automatic read(input logic [9:0] a);
      @(posedge clk);
      plc_rd_req <= 1'h1;
      {plc_rd_rack, plc_rd_quarter} <= a;
      @(posedge clk);
      plc_rd_req <= '0;
      {plc_rd_rack, plc_rd_quarter} <= ~a;
   endtask
endmodule
`default_nettype wire

// ### tb/scale_plc_quarter_rack_io_tb.sv
// self-checking bench of the quarter rack exchange block
`default_nettype none
module scale_plc_quarter_rack_io_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [15:0] w0; logic [15:0] w1;} rd_t;
   typedef logic [10:0] ev_t;
   localparam logic [9:0] addr = {7'h05, 3'h2};
   logic clk = '0, arst_n = '0, ad_sample = '0, ad_seen = '0;
   logic [6:0] cfg_rack_addr = 7'h05;
   logic [2:0] cfg_start_quarter = 3'h2;
   logic [15:0] gross_weight = '0, net_weight = '0, displayed_weight = '0;
   logic [15:0] tare_weight = '0, active_target = '0, cmd = '0, sp1 = '0, v;
   logic over_range = '0, under_range = '0, powering_up = '0, expanded_mode = '0;
   logic setup_mode = '0, motion = '0, net_mode = '0, discrete_input_level = '0;
   logic over_under_mode = '0, sp1_output = '0, sp2_output = '0, zero_tol_output = '0;
   logic under_output = '0, in_tol_output = '0, over_output = '0, indicator_mode = 1'h1;
   logic tare_interlock = '0, tare_in_use = '0, gross_at_zero = 1'h1;
   logic plc_wr_valid, plc_rd_req, plc_rd_valid, preset_tare_load, clear_tare_cmd;
   logic pb_tare_cmd, print_cmd, zero_cmd, setpoint1_load, nv_store, high_level_enable;
   logic parallel_output_one, parallel_output_two, parallel_output_three;
   logic [6:0] plc_wr_rack, plc_rd_rack;
   logic [2:0] plc_wr_quarter, plc_rd_quarter;
   logic [15:0] plc_wr_word0, plc_wr_word1, plc_rd_word0, plc_rd_word1;
   logic [15:0] preset_tare, setpoint1_value, nv_setpoint1;
   rd_t rd_q[$];
   ev_t ev_q[$];
   rd_t snap = '0;
   ev_t lvl = '0;
   int n_fail = 0, n_checks = 0;
   always #20 clk = ~clk;
   scale_plc_quarter_rack_io scale_plc_quarter_rack_io_i (.*);
   plc_model plc_model_i (.*);
   function automatic rd_t snap_now();
      rd_t r;
      logic ok;
      ok = !(over_range | under_range | powering_up | expanded_mode | setup_mode);
      case (cmd[2:0])
         3'h1: r.w0 = net_weight;
         3'h2: r.w0 = displayed_weight;
         3'h3: r.w0 = over_under_mode ? active_target : tare_weight;
         3'h4: r.w0 = sp1;
         default: r.w0 = gross_weight;
      endcase
      r.w0 = ok ? r.w0 : '0;
      r.w1 = {ok, 1'h0, net_mode, motion, 2'h0, discrete_input_level, 6'h00, over_under_mode ?
         {over_output, in_tol_output, under_output} : {zero_tol_output, sp2_output, sp1_output}};
      return r;
   endfunction
   task automatic note(input logic ok, input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (!ok) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_rd(input rd_t g);
      logic h;
      rd_t e;
      h = rd_q.size() > 0;
      e = h ? rd_q.pop_front() : '0;
      note(h && g === e, g, e);
   endtask
   task automatic chk_ev(input ev_t g);
      logic h;
      ev_t e;
      h = ev_q.size() > 0;
      e = h ? ev_q.pop_front() : '0;
      note(h && g === e, 32'(g), 32'(e));
   endtask
   task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
      note(g === e, 32'(g), 32'(e));
   endtask
   // commands act only at the conversion pulse
   task automatic sample(input ev_t e);
      @(posedge clk);
      ad_sample <= 1'h1;
      @(posedge clk);
      ad_sample <= '0;
      ev_q.push_back(e);
      lvl = e & 11'h00f;
      snap = snap_now();
      #1;
   endtask
   task automatic step(input logic [15:0] w0, input logic [15:0] w1, input ev_t e);
      plc_model_i.write(addr, w0, w1);
      cmd = w1;
      sample(e);
   endtask
   task automatic rd(input logic upd);
      rd_t e;
      e = snap;
      e.w1[14] = upd;
      rd_q.push_back(e);
      if (upd) fork
         plc_model_i.read(addr);
         sample(lvl);
      join
      else plc_model_i.read(addr);
   endtask
   task automatic finish_test();
      n_fail += rd_q.size() + ev_q.size();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (ad_seen) chk_ev({preset_tare_load, clear_tare_cmd, pb_tare_cmd, print_cmd, zero_cmd,
         setpoint1_load, nv_store, high_level_enable, parallel_output_one, parallel_output_two,
         parallel_output_three});
      if (plc_rd_valid === 1'h1) chk_rd({plc_rd_word0, plc_rd_word1});
      ad_seen <= ad_sample;
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h94582283));
      repeat (20) @(posedge clk);
      arst_n <= 1'h1;
      v = 16'($urandom);
      step(v, 16'h0008, 11'h400);
      chk_val(preset_tare, v);
      step(~v, 16'h0008, '0);
      chk_val(preset_tare, v);
      for (int b = 4; b < 8; b++) begin
         step('0, '0, '0);
         step('0, 16'h0001 << b, 11'h400 >> (b - 3));
      end
      {tare_interlock, tare_in_use, gross_at_zero} <= 3'h6;
      step('0, 16'h0038, '0);
      step('0, '0, '0);
      {tare_in_use, gross_at_zero} <= 2'h1;
      step('0, 16'h0030, 11'h300);
      tare_interlock <= '0;
      v = 16'($urandom);
      step(v, 16'h8000, 11'h020);
      chk_val(setpoint1_value, v);
      step('0, 16'h8100, 11'h018);
      chk_val(nv_setpoint1, v);
      step('0, 16'h0100, 11'h008);
      v = 16'($urandom);
      step(v, 16'h8100, 11'h038);
      chk_val(nv_setpoint1, v);
      sp1 = v;
      step('0, 16'h7000, 11'h007);
      indicator_mode <= '0;
      step('0, 16'h1e00, 11'h007);
      indicator_mode <= 1'h1;
      step('0, 16'h5000, 11'h005);
      for (int s = 0; s < 8; s++) begin
         {motion, net_mode, discrete_input_level, over_under_mode, sp1_output, sp2_output,
            zero_tol_output, under_output, in_tol_output, over_output} <= 10'($urandom);
         {gross_weight, net_weight, displayed_weight, tare_weight, active_target} <=
            80'({$urandom, $urandom, $urandom});
         step('0, 16'(s), '0);
         rd(1'h0);
      end
      rd(1'h1);
      rd(1'h0);
      for (int i = 0; i < 5; i++) begin
         {over_range, under_range, powering_up, expanded_mode, setup_mode} <= 5'h01 << i;
         sample(lvl);
         rd(1'h0);
      end
      plc_model_i.read(addr ^ 10'h008);
      // a quarter outside 1 to 4 must never answer, even when it matches
      cfg_start_quarter <= 3'h0;
      plc_model_i.read({7'h05, 3'h0});
      cfg_start_quarter <= 3'h2;
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
bind scale_plc_quarter_rack_io scale_io_sva #(.WIDTH(WIDTH)) scale_io_sva_i (.*);
`default_nettype wire
